// >>> rtl/wdtrc_top.sv
// Watchdog timer control with reset-cause status flags, AXI4-Lite slave.
// Assumes the reset controller holds this block alive across system resets
// other than power-on, and reports each reset cause as a one-cycle pulse.
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module wdtrc_top #(
  parameter int SLOW_DIV = wdtrc_pkg::SLOW_DIV
) (
  // Clock and reset
  input  wire logic                  REF_CLK,
  input  wire logic                  RST_B,
  // Reset controller and processor side
  input  wire wdtrc_pkg::wdtrc_cause_t CAUSE,
  input  wire logic                  ALWAYS_ON_FUSE,
  input  wire logic                  VECTOR_TAKEN,
  output logic                       WDOG_RESET_REQ,
  output logic                       TIMEOUT_IRQ,
  // AXI4-Lite write address
  input  wire logic [11:0]           AWADDR,
  input  wire logic                  AWVALID,
  output logic                       AWREADY,
  // AXI4-Lite write data
  input  wire logic [31:0]           WDATA,
  input  wire logic [3:0]            WSTRB,
  input  wire logic                  WVALID,
  output logic                       WREADY,
  // AXI4-Lite write response
  output logic [1:0]                 BRESP,
  output logic                       BVALID,
  input  wire logic                  BREADY,
  // AXI4-Lite read
  input  wire logic [11:0]           ARADDR,
  input  wire logic                  ARVALID,
  output logic                       ARREADY,
  output logic [31:0]                RDATA,
  output logic [1:0]                 RRESP,
  output logic                       RVALID,
  input  wire logic                  RREADY
);

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  logic              irq_flag;
  logic              irq_enable;
  logic [3:0]        tsel;
  logic              unlock;
  logic              reset_en;
  logic [3:0]        cause;
  logic              global_irq;
  logic [2:0]        unlock_cnt;
  logic [15:0]       div_cnt;
  logic              slow_tick;
  logic [20:0]       wd_cnt;
  logic              timeout;
  logic              aw_held;
  logic              w_held;
  logic [11:0]       aw_addr;
  logic [31:0]       w_data;
  logic              wstrb0;
  logic              w_lane0;
  logic              wr_go;
  logic              wr_ctl;
  logic              wr_cause;
  logic              wr_core;
  logic              eff_enable;
  logic              eff_irq_en;
  wdtrc_pkg::wdtrc_mode_t mode;

  // Time-out length in slow cycles for a select code
  function automatic logic [20:0] limit_of(input logic [3:0] code);
    logic [3:0] c;
    c = (code > wdtrc_pkg::SELECT_MAX) ? wdtrc_pkg::SELECT_MAX : code;
    limit_of = 21'h000800 << c;
  endfunction

  // --------------------------------------------------------------------
  // Write channel: address and data taken in either order
  // --------------------------------------------------------------------
  assign AWREADY = !aw_held && !BVALID;
  assign WREADY  = !w_held && !BVALID;
  assign wr_go   = aw_held && w_held && !BVALID;
  // Only byte lane 0 carries register bits; other lanes alone do nothing
  assign w_lane0 = w_held && wstrb0;

  // Latch write halves until both present
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 12'h000;
      w_data  <= 32'h0000_0000;
      wstrb0  <= 1'b0;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_held <= 1'b1;
        aw_addr <= AWADDR;
      end
      if (WVALID && WREADY) begin
        w_held <= 1'b1;
        w_data <= WDATA;
        wstrb0 <= WSTRB[0];
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
      end
    end
  end

  assign wr_ctl   = wr_go && w_lane0 && aw_addr == wdtrc_pkg::WATCHDOG_CONTROL_STATUS_OFS;
  assign wr_cause = wr_go && w_lane0 && aw_addr == wdtrc_pkg::RESET_CAUSE_STATUS_OFS;
  assign wr_core  = wr_go && w_lane0 && aw_addr == wdtrc_pkg::CORE_CONTROL_OFS;

  // Write response one cycle after both halves are in
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      BVALID <= 1'b0;
      BRESP  <= wdtrc_pkg::RESP_OKAY;
    end else if (wr_go) begin
      BVALID <= 1'b1;
      BRESP  <= (aw_addr == wdtrc_pkg::WATCHDOG_CONTROL_STATUS_OFS ||
                 aw_addr == wdtrc_pkg::RESET_CAUSE_STATUS_OFS ||
                 aw_addr == wdtrc_pkg::CORE_CONTROL_OFS) ?
                wdtrc_pkg::RESP_OKAY : wdtrc_pkg::RESP_SLVERR;
    end else if (BREADY) begin
      BVALID <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Read channel
  // --------------------------------------------------------------------
  assign ARREADY = !RVALID;

  // One-cycle read latency; unmapped answers SLVERR with zero data
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      RVALID <= 1'b0;
      RDATA  <= 32'h0000_0000;
      RRESP  <= wdtrc_pkg::RESP_OKAY;
    end else if (ARVALID && ARREADY) begin
      RVALID <= 1'b1;
      RRESP  <= wdtrc_pkg::RESP_OKAY;
      unique case (ARADDR)
        wdtrc_pkg::WATCHDOG_CONTROL_STATUS_OFS: begin
          RDATA <= {24'h000000, irq_flag, eff_irq_en, tsel[3], unlock,
                    eff_enable, tsel[2:0]};
        end
        wdtrc_pkg::RESET_CAUSE_STATUS_OFS: begin
          RDATA <= {28'h0000000, cause};
        end
        wdtrc_pkg::CORE_CONTROL_OFS: begin
          RDATA <= {30'h0, global_irq, 1'b0};
        end
        default: begin
          RDATA <= 32'h0000_0000;
          RRESP <= wdtrc_pkg::RESP_SLVERR;
        end
      endcase
    end else if (RREADY) begin
      RVALID <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Mode decode
  // --------------------------------------------------------------------
  // watchdog cause forces enable; fuse locks enable and irq enable
  assign eff_enable = reset_en || cause[wdtrc_pkg::WDOG_CAUSE_POS] || !ALWAYS_ON_FUSE;
  assign eff_irq_en = irq_enable && ALWAYS_ON_FUSE;

  // pair selects the mode; programmed fuse forces reset mode
  always_comb begin
    if (!ALWAYS_ON_FUSE) begin
      mode = wdtrc_pkg::WDTRC_RESET;
    end else begin
      mode = wdtrc_pkg::wdtrc_mode_t'({eff_enable, eff_irq_en});
    end
  end

  // --------------------------------------------------------------------
  // Slow tick divider and watchdog counter
  // --------------------------------------------------------------------
  // Slow oscillator modelled as an enable pulse from the reference clock
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      div_cnt   <= 16'h0000;
      slow_tick <= 1'b0;
    end else if (div_cnt == 16'(SLOW_DIV - 1)) begin
      div_cnt   <= 16'h0000;
      slow_tick <= 1'b1;
    end else begin
      div_cnt   <= div_cnt + 16'h0001;
      slow_tick <= 1'b0;
    end
  end

  // time-out at the selected count of slow cycles
  assign timeout = slow_tick && mode != wdtrc_pkg::WDTRC_STOPPED &&
                   wd_cnt == limit_of(tsel) - 21'h000001;

  // count slow ticks, restart command zeroes; zero after time-out
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      wd_cnt <= 21'h000000;
    end else if ((wr_core && w_data[wdtrc_pkg::RESTART_POS]) || timeout ||
                 mode == wdtrc_pkg::WDTRC_STOPPED) begin
      wd_cnt <= 21'h000000;
    end else if (slow_tick) begin
      wd_cnt <= wd_cnt + 21'h000001;
    end
  end

  // reset action in reset mode; combined mode resets if flag unserviced
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      WDOG_RESET_REQ <= 1'b0;
    end else begin
      WDOG_RESET_REQ <= timeout && (mode == wdtrc_pkg::WDTRC_RESET ||
                        (mode == wdtrc_pkg::WDTRC_BOTH && irq_flag));
    end
  end

  // --------------------------------------------------------------------
  // Control register fields
  // --------------------------------------------------------------------
  // Interrupt flag: set wins over vector and write-one clears
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      irq_flag <= wdtrc_pkg::CONTROL_RESET[wdtrc_pkg::IRQ_FLAG_POS];
    end else if (timeout && eff_irq_en) begin
      // set on time-out with interrupt configured
      irq_flag <= 1'b1;
    end else if (VECTOR_TAKEN) begin
      irq_flag <= 1'b0;
    end else if (wr_ctl && w_data[wdtrc_pkg::IRQ_FLAG_POS]) begin
      irq_flag <= 1'b0;
    end
  end

  // request gated by flag, enable and global enable
  assign TIMEOUT_IRQ = irq_flag && eff_irq_en && global_irq;

  // Interrupt enable
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      irq_enable <= wdtrc_pkg::CONTROL_RESET[wdtrc_pkg::IRQ_ENABLE_POS];
    end else if (wr_ctl) begin
      irq_enable <= w_data[wdtrc_pkg::IRQ_ENABLE_POS];
    end else if (VECTOR_TAKEN && mode == wdtrc_pkg::WDTRC_BOTH) begin
      irq_enable <= 1'b0;
    end
  end

  // Enable and select, guarded by the unlock window
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      reset_en <= wdtrc_pkg::CONTROL_RESET[wdtrc_pkg::RESET_EN_POS];
      tsel     <= 4'h0;
    end else if (wr_ctl) begin
      // clear enable or new select only while unlocked
      if (unlock) begin
        reset_en <= w_data[wdtrc_pkg::RESET_EN_POS];
        tsel     <= {w_data[wdtrc_pkg::SELECT_HI_POS], w_data[2:0]};
      end else if (w_data[wdtrc_pkg::RESET_EN_POS]) begin
        reset_en <= 1'b1;
      end
    end
  end

  // unlock closes four cycles after a written one
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      unlock     <= 1'b0;
      unlock_cnt <= 3'h0;
    end else if (wr_ctl && w_data[wdtrc_pkg::UNLOCK_POS] &&
                 w_data[wdtrc_pkg::RESET_EN_POS]) begin
      unlock     <= 1'b1;
      unlock_cnt <= 3'(wdtrc_pkg::UNLOCK_CYCLES - 1);
    end else if (wr_ctl || unlock_cnt == 3'h0) begin
      unlock     <= 1'b0;
    end else begin
      unlock_cnt <= unlock_cnt - 3'h1;
    end
  end

  // Global interrupt enable held for the processor status word
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      global_irq <= 1'b0;
    end else if (wr_core) begin
      global_irq <= w_data[wdtrc_pkg::GLOBAL_IRQ_POS];
    end
  end

  // --------------------------------------------------------------------
  // Reset cause flags; set always wins over a written zero
  // --------------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      cause <= wdtrc_pkg::CAUSE_RESET;
    end else if (CAUSE.poweron) begin
      // power-on sets its flag; power-on clears the others
      cause <= 4'h1;
    end else begin
      cause <= (wr_cause ? (cause & w_data[3:0]) : cause) |
               {CAUSE.watchdog, CAUSE.brownout, CAUSE.pin, 1'b0};
    end
  end

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  property p_unlock_close;
    @(posedge REF_CLK) disable iff (!RST_B)
      $rose(unlock) && !wr_ctl ##1 !wr_ctl [*4] |-> !unlock && $past(unlock);
  endproperty
  a_unlock_close: assert property (p_unlock_close) else $error("unlock stayed open");

  property p_flag_set;
    @(posedge REF_CLK) disable iff (!RST_B) timeout && eff_irq_en |=> irq_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set on time-out");

  property p_vector_clear;
    @(posedge REF_CLK) disable iff (!RST_B)
      VECTOR_TAKEN && !(timeout && eff_irq_en) |=> !irq_flag;
  endproperty
  a_vector_clear: assert property (p_vector_clear) else $error("vector left flag");

  property p_irq_gate;
    @(posedge REF_CLK) disable iff (!RST_B)
      TIMEOUT_IRQ |-> irq_flag && irq_enable && global_irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("ungated interrupt");

  property p_fuse_mode;
    @(posedge REF_CLK) disable iff (!RST_B)
      !ALWAYS_ON_FUSE && timeout |=> WDOG_RESET_REQ;
  endproperty
  a_fuse_mode: assert property (p_fuse_mode) else $error("fuse reset missing");

  property p_enable_held;
    @(posedge REF_CLK) disable iff (!RST_B) cause[3] |-> eff_enable;
  endproperty
  a_enable_held: assert property (p_enable_held) else $error("enable dropped");

  property p_locked_sel;
    @(posedge REF_CLK) disable iff (!RST_B) !unlock |=> $stable(tsel);
  endproperty
  a_locked_sel: assert property (p_locked_sel) else $error("select changed locked");

  property p_poweron_reset_cause_flag_kept;
    @(posedge REF_CLK) disable iff (!RST_B)
      cause[0] && !wr_cause |=> cause[0];
  endproperty
  a_poweron_reset_cause_flag_kept: assert property (p_poweron_reset_cause_flag_kept) else $error("power-on flag lost");

  property p_both_reset;
    @(posedge REF_CLK) disable iff (!RST_B)
      mode == wdtrc_pkg::WDTRC_BOTH && irq_flag && timeout |=> WDOG_RESET_REQ;
  endproperty
  a_both_reset: assert property (p_both_reset) else $error("combined reset missing");

endmodule

`default_nettype wire

// >>> rtl/wdtrc_pkg.sv
// Package for the watchdog with reset-cause flags.
// Assumes a single 25 MHz clock domain and an AXI4-Lite register port.
package wdtrc_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [11:0] WATCHDOG_CONTROL_STATUS_OFS = 12'h060;
  localparam logic [11:0] RESET_CAUSE_STATUS_OFS      = 12'h064;
  localparam logic [11:0] CORE_CONTROL_OFS            = 12'h068;

  // ----------------------------------------------------------------------
  // Control register field positions
  // ----------------------------------------------------------------------
  localparam int IRQ_FLAG_POS   = 7;
  localparam int IRQ_ENABLE_POS = 6;
  localparam int SELECT_HI_POS  = 5;
  localparam int UNLOCK_POS     = 4;
  localparam int RESET_EN_POS   = 3;

  // Reset-cause field positions
  localparam int WDOG_CAUSE_POS  = 3;
  localparam int BROWN_CAUSE_POS = 2;
  localparam int PIN_CAUSE_POS   = 1;
  localparam int PWR_CAUSE_POS   = 0;

  // Core control register: restart pulse (bit 0), global irq enable (bit 1)
  localparam int RESTART_POS     = 0;
  localparam int GLOBAL_IRQ_POS  = 1;

  // ----------------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------------
  localparam logic [7:0] CONTROL_RESET    = 8'h00;
  localparam logic [3:0] CAUSE_RESET      = 4'h0;
  localparam logic [3:0] SELECT_MAX       = 4'h9;
  localparam int         UNLOCK_CYCLES    = 4;
  localparam int         BASE_TIMEOUT_LOG = 11;   // 2k oscillator cycles
  localparam int         SLOW_OSC_HZ      = 128000;
  localparam int         REF_CLK_HZ       = 25000000;
  localparam int         SLOW_DIV         = REF_CLK_HZ / SLOW_OSC_HZ;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Mode decoded from fuse and enable pair
  typedef enum logic [1:0] {
    WDTRC_STOPPED = 2'h0,
    WDTRC_IRQ     = 2'h1,
    WDTRC_BOTH    = 2'h3,
    WDTRC_RESET   = 2'h2
  } wdtrc_mode_t;

  // Reset cause requests from the reset controller
  typedef struct packed {
    logic watchdog;
    logic brownout;
    logic pin;
    logic poweron;
  } wdtrc_cause_t;

endpackage

// >>> bench/wdtrc_cpu_model.sv
// Processor and reset-controller stand-in facing the watchdog block.
// Assumes one clock; serve is driven by the bench to allow vector entry.
`timescale 1ns/1ps
`default_nettype none

module wdtrc_cpu_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Requests from the watchdog, and serve from the bench
  input  wire logic irq,
  input  wire logic rst_req,
  input  wire logic serve,
  // Answers to the watchdog
  output logic      vector_taken,
  output logic      wd_cause
);
  logic [1:0] dly;

  // -------------------------------------------------------------------
  // Vector entry
  // -------------------------------------------------------------------
  // Enter the vector a few cycles late, as a real core finishes an
  // instruction first; no second entry while the pulse is out
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dly          <= 2'h0;
      vector_taken <= 1'b0;
    end else begin
      vector_taken <= 1'b0;
      dly          <= 2'h0;
      if (irq && serve && !vector_taken) begin
        dly <= dly + 2'h1;
        if (dly == 2'h3) begin
          vector_taken <= 1'b1;
        end
      end
    end
  end

  // Reset controller reports a watchdog reset one cycle later
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wd_cause <= 1'b0;
    end else begin
      wd_cause <= rst_req;
    end
  end
endmodule

`default_nettype wire

// >>> bench/test_watchdog_and_reset_cause_flags.sv
// Self-checking bench for the watchdog with reset-cause flags.
// Assumes the package, the block and the processor model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module test_watchdog_and_reset_cause_flags;
  localparam int          DIV = 2;
  localparam int          P0  = 2048 * DIV;  // Time-out at select code 0
  localparam logic [11:0] CTL = wdtrc_pkg::WATCHDOG_CONTROL_STATUS_OFS;
  localparam logic [11:0] CAU = wdtrc_pkg::RESET_CAUSE_STATUS_OFS;
  localparam logic [11:0] COR = wdtrc_pkg::CORE_CONTROL_OFS;
  localparam logic [1:0]  OK  = wdtrc_pkg::RESP_OKAY;
  localparam logic [1:0]  ERR = wdtrc_pkg::RESP_SLVERR;

  logic                    REF_CLK, RST_B, ALWAYS_ON_FUSE, VECTOR_TAKEN;
  logic                    WDOG_RESET_REQ, TIMEOUT_IRQ, serve, wd_c;
  logic [2:0]              tb_cause;
  wdtrc_pkg::wdtrc_cause_t cause;
  logic [11:0]             AWADDR, ARADDR;
  logic [31:0]             WDATA, RDATA;
  logic [3:0]              WSTRB, s;
  logic                    AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic                    ARVALID, ARREADY, RVALID, RREADY;
  logic [1:0]              BRESP, RRESP;
  int                      n_mismatch, total_checks, n_rst, seed, n;
  logic [1:0]              exp_b[$];
  logic [33:0]             exp_r[$];

  assign cause = {wd_c, tb_cause};

  wdtrc_top #(.SLOW_DIV(DIV)) dut (
    .REF_CLK(REF_CLK), .RST_B(RST_B), .CAUSE(cause), .ALWAYS_ON_FUSE(ALWAYS_ON_FUSE),
    .VECTOR_TAKEN(VECTOR_TAKEN), .WDOG_RESET_REQ(WDOG_RESET_REQ), .TIMEOUT_IRQ(TIMEOUT_IRQ),
    .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
    .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
    .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
    .RVALID(RVALID), .RREADY(RREADY));

  wdtrc_cpu_model cpu (
    .clk(REF_CLK), .rst_b(RST_B), .irq(TIMEOUT_IRQ), .rst_req(WDOG_RESET_REQ),
    .serve(serve), .vector_taken(VECTOR_TAKEN), .wd_cause(wd_c));

  // -------------------------------------------------------------------
  // Checking and bus tasks
  // -------------------------------------------------------------------
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] e);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    exp_b.push_back(e);
    AWADDR <= a;
    WDATA <= {24'h0, d};
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge REF_CLK);
      if (AWVALID && AWREADY === 1'b1) begin
        aw_done = 1'b1;
        AWVALID <= 1'b0;
      end
      if (WVALID && WREADY === 1'b1) begin
        w_done = 1'b1;
        WVALID <= 1'b0;
      end
    end
    do @(posedge REF_CLK); while (BVALID !== 1'b1);
  endtask

  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    exp_r.push_back(e);
    ARADDR <= a;
    ARVALID <= 1'b1;
    do @(posedge REF_CLK); while (ARREADY !== 1'b1);
    ARVALID <= 1'b0;
    do @(posedge REF_CLK); while (RVALID !== 1'b1);
  endtask

  task automatic pulse(input logic [2:0] m);
    tb_cause <= m;
    @(posedge REF_CLK);
    tb_cause <= 3'h0;
    @(posedge REF_CLK);
  endtask

  // Bounded wait for the interrupt level or a reset pulse
  task automatic wait_sig(input bit rq, input int lim, output int cnt);
    cnt = 0;
    do begin
      @(posedge REF_CLK);
      cnt++;
    end while ((rq ? WDOG_RESET_REQ : TIMEOUT_IRQ) !== 1'b1 && cnt < lim);
  endtask

  // Oldest note taken off whenever a response is handed over
  always @(posedge REF_CLK) begin
    if (BVALID === 1'b1 && BREADY) chk({32'h0, BRESP}, {32'h0, exp_b.pop_front()});
    if (RVALID === 1'b1 && RREADY) chk({RRESP, RDATA}, exp_r.pop_front());
    if (WDOG_RESET_REQ === 1'b1) n_rst++;
  end

  initial begin
    REF_CLK = 1'b0;
    forever #20 REF_CLK = ~REF_CLK;
  end

  // Hang guard, well above the expected run length
  initial begin
    repeat (60000) @(posedge REF_CLK);
    n_mismatch++;
    results();
  end

  // -------------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------------
  initial begin
    seed = 32'h7d66;
    {RST_B, ALWAYS_ON_FUSE, serve, tb_cause} = 6'h10;
    {AWVALID, WVALID, ARVALID, BREADY, RREADY} = 5'h03;
    {AWADDR, ARADDR, WDATA, WSTRB} = {56'h0, 4'hf};
    repeat (12) @(posedge REF_CLK);
    RST_B <= 1'b1;
    @(posedge REF_CLK);
    // Reset values and an unmapped place
    rd(CTL, {OK, 32'h00});
    rd(CAU, {OK, 32'h00});
    rd(12'h100, {ERR, 32'h00});
    wr(12'h100, 8'hff, ERR);
    // Write without byte lane 0 leaves the register alone
    WSTRB <= 4'h0;
    wr(CTL, 8'h40, OK);
    WSTRB <= 4'hf;
    rd(CTL, {OK, 32'h00});
    // Power-on, pin and brownout each set their flag; zero or power-on clears
    pulse(3'h1);
    rd(CAU, {OK, 32'h01});
    pulse(3'h4);
    pulse(3'h2);
    rd(CAU, {OK, 32'h07});
    wr(CAU, 8'h06, OK);
    rd(CAU, {OK, 32'h06});
    pulse(3'h1);
    rd(CAU, {OK, 32'h01});
    wr(CAU, 8'h00, OK);
    // Interrupt mode: time-out length, write-one clear, global gate
    wr(CTL, 8'h40, OK);
    wr(COR, 8'h03, OK);
    wait_sig(0, P0 + 100, n);
    chk(34'(n >= P0 - 8 && n <= P0 + 8), 34'h1);
    rd(CTL, {OK, 32'hc0});
    wr(CTL, 8'h40, OK);
    rd(CTL, {OK, 32'hc0});
    chk({33'h0, TIMEOUT_IRQ}, 34'h1);
    wr(COR, 8'h00, OK);
    @(posedge REF_CLK);
    chk({33'h0, TIMEOUT_IRQ}, 34'h0);
    wr(CTL, 8'hc0, OK);
    rd(CTL, {OK, 32'h40});
    // Vector entry clears only the flag in interrupt mode
    wr(COR, 8'h02, OK);
    serve <= 1'b1;
    wait_sig(0, P0 + 100, n);
    repeat (8) @(posedge REF_CLK);
    rd(CTL, {OK, 32'h40});
    chk(34'(n_rst), 34'h0);
    // Combined mode left unserviced resets at the next time-out
    serve <= 1'b0;
    wr(CTL, 8'h48, OK);
    wr(COR, 8'h03, OK);
    wait_sig(0, P0 + 100, n);
    rd(CTL, {OK, 32'hc8});
    wait_sig(1, P0 + 100, n);
    chk(34'(n >= P0 - 40 && n <= P0 + 8), 34'h1);
    repeat (2) @(posedge REF_CLK);
    rd(CAU, {OK, 32'h08});
    // Combined mode serviced: vector drops to reset-only mode
    wr(CTL, 8'hc8, OK);
    serve <= 1'b1;
    wait_sig(0, P0 + 100, n);
    repeat (8) @(posedge REF_CLK);
    rd(CTL, {OK, 32'h08});
    serve <= 1'b0;
    wait_sig(1, P0 + 100, n);
    chk(34'(n < P0 + 100), 34'h1);
    // Enable held while the watchdog cause is set
    wr(CTL, 8'h18, OK);
    wr(CTL, 8'h00, OK);
    rd(CTL, {OK, 32'h08});
    wr(COR, 8'h01, OK);
    wr(CAU, 8'h00, OK);
    // Timed change of random select codes
    for (int i = 0; i < 3; i++) begin
      s = 4'($unsigned($random(seed)) % 10);
      wr(CTL, 8'h18, OK);
      wr(CTL, {2'h0, s[3], 2'h0, s[2:0]}, OK);
      rd(CTL, {OK, 24'h0, 2'h0, s[3], 2'h0, s[2:0]});
    end
    // Window closed after four cycles: change refused
    wr(CTL, 8'h18, OK);
    repeat (6) @(posedge REF_CLK);
    wr(CTL, 8'h05, OK);
    rd(CTL, {OK, 24'h0, 2'h0, s[3], 2'h1, s[2:0]});
    // Programmed fuse forces reset mode at the shortest time-out
    wr(CTL, 8'h18, OK);
    wr(CTL, 8'h08, OK);
    wr(COR, 8'h03, OK);
    ALWAYS_ON_FUSE <= 1'b0;
    wr(CTL, 8'h40, OK);
    rd(CTL, {OK, 32'h08});
    wait_sig(1, P0 + 100, n);
    wait_sig(1, P0 + 100, n);
    chk(34'(n >= P0 - 2 && n <= P0 + 2), 34'h1);
    chk({33'h0, TIMEOUT_IRQ}, 34'h0);
    results();
  end
endmodule

`default_nettype wire
